// file: src/lam_alert.sv
module lam_alert
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire lam_pkg::lam_reg_req_t i_req,
    input wire lam_pkg::lam_ool_t i_ool,
    input wire logic i_pwm_channel_two,
    output logic [7:0] o_rdata,
    output logic o_pin_o,
    output logic o_pin_oe
);
    import lam_pkg::*;

    lam_state_t q;
    lam_state_t d;
    logic rd_one;
    logic rd_two;
    logic [7:0] eff_mask_two;
    logic [6:0] pend_one;
    logic [7:0] pend_two;
    logic alert_active;
    logic alert_mode;

    // ==========================================
    // Decode and alert gating
    assign rd_one = i_req.rd && (i_req.addr == LAM_ADDR_STATUS_ONE);
    assign rd_two = i_req.rd && (i_req.addr == LAM_ADDR_STATUS_TWO);
    // Second mask counts only when enabled by the first mask
    assign eff_mask_two = q.mask_two & {8{q.mask_one[LAM_BIT_SUMMARY]}};
    // Temperature and voltage gating, bit for bit
    assign pend_one = q.status_one & ~q.mask_one[6:0];
    // Diode, fan, overtemperature and 12 V gating
    assign pend_two = q.status_two & ~eff_mask_two;
    assign alert_active = (|pend_one) || (|pend_two);
    assign alert_mode = q.config_three[LAM_BIT_ALERT_SELECT];

    // ==========================================
    // Next state
    always_comb
    begin
        d = q;
        // Set wins over read clear
        d.status_one = i_ool.one | (q.status_one & ~{7{rd_one}});
        d.status_two = i_ool.two | (q.status_two & ~{8{rd_two}});
        if (i_req.wr)
        begin
            case (i_req.addr)
                LAM_ADDR_MASK_ONE: d.mask_one = i_req.wdata;
                LAM_ADDR_MASK_TWO: d.mask_two = i_req.wdata;
                LAM_ADDR_CONFIG_THREE: d.config_three = i_req.wdata;
                default: d.config_three = q.config_three;
            endcase
        end
        if (i_req.rd)
        begin
            case (i_req.addr)
                LAM_ADDR_STATUS_ONE: d.rdata = {(|q.status_two), q.status_one};
                LAM_ADDR_STATUS_TWO: d.rdata = q.status_two;
                LAM_ADDR_MASK_ONE: d.rdata = q.mask_one;
                LAM_ADDR_MASK_TWO: d.rdata = q.mask_two;
                LAM_ADDR_CONFIG_THREE: d.rdata = q.config_three;
                default: d.rdata = LAM_RDATA_UNMAPPED;
            endcase
        end
        // Shared pin: alert pulls low only, PWM drives both levels
        if (q.config_three[LAM_BIT_ALERT_SELECT])
        begin
            d.pin_o = 1'b0;
            d.pin_oe = alert_active;
        end
        else
        begin
            d.pin_o = i_pwm_channel_two;
            d.pin_oe = 1'b1;
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            q.status_one <= LAM_RST_STATUS[6:0];
            q.status_two <= LAM_RST_STATUS;
            q.mask_one <= LAM_RST_MASK;
            q.mask_two <= LAM_RST_MASK;
            q.config_three <= LAM_RST_CONFIG;
            q.rdata <= LAM_RDATA_UNMAPPED;
            q.pin_o <= 1'b0;
            q.pin_oe <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_rdata = q.rdata;
    assign o_pin_o = q.pin_o;
    assign o_pin_oe = q.pin_oe;

    // ==========================================
    // Assertions
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);

    property p_status_set;
        (i_ool.one != 7'h00 || i_ool.two != 8'h00) |=>
            ((q.status_one & $past(i_ool.one)) == $past(i_ool.one))
            && ((q.status_two & $past(i_ool.two)) == $past(i_ool.two));
    endproperty
    a_status_set: assert property (p_status_set) else $error("status bit not set");

    property p_sticky;
        !(i_req.rd && (i_req.addr == LAM_ADDR_STATUS_ONE || i_req.addr == LAM_ADDR_STATUS_TWO)) |=>
            ((q.status_one & $past(q.status_one)) == $past(q.status_one))
            && ((q.status_two & $past(q.status_two)) == $past(q.status_two));
    endproperty
    a_sticky: assert property (p_sticky) else $error("status bit dropped without read");

    property p_read_clear;
        (rd_one && i_ool.one == 7'h00) |=> (q.status_one == 7'h00);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear ended flag");

    property p_summary;
        (i_req.rd && i_req.addr == LAM_ADDR_STATUS_ONE) |=> (o_rdata[7] == $past(|q.status_two));
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit wrong");

    property p_alert_low;
        (q.config_three[0] && alert_active) |=> (o_pin_oe && !o_pin_o);
    endproperty
    a_alert_low: assert property (p_alert_low) else $error("alert not driven low");

    property p_alert_release;
        (q.config_three[0] && !alert_active) |=> !o_pin_oe;
    endproperty
    a_alert_release: assert property (p_alert_release) else $error("alert held with nothing pending");

    property p_mask_two_gate;
        (q.config_three[0] && !q.mask_one[7] && q.status_two != 8'h00) |=> o_pin_oe;
    endproperty
    a_mask_two_gate: assert property (p_mask_two_gate) else $error("second mask acted while disabled");

    property p_masked_sets;
        (q.mask_two == 8'hFF && q.mask_one[7] && i_ool.two != 8'h00) |=> (q.status_two != 8'h00);
    endproperty
    a_masked_sets: assert property (p_masked_sets) else $error("masked source lost status");

    property p_mask_write;
        (i_req.wr && i_req.addr == LAM_ADDR_MASK_ONE) |=> (q.mask_one == $past(i_req.wdata));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask one write lost");

    property p_pwm_mode;
        !q.config_three[0] |=> (o_pin_oe && o_pin_o == $past(i_pwm_channel_two));
    endproperty
    a_pwm_mode: assert property (p_pwm_mode) else $error("pin not following pwm");

    // ==========================================
    // Register port and open-drain pin checks
    property p_mask_two_write;
        (i_req.wr && i_req.addr == LAM_ADDR_MASK_TWO) |=> (q.mask_two == $past(i_req.wdata));
    endproperty
    a_mask_two_write: assert property (p_mask_two_write) else $error("mask two write lost");

    property p_config_write;
        (i_req.wr && i_req.addr == LAM_ADDR_CONFIG_THREE) |=> (q.config_three == $past(i_req.wdata));
    endproperty
    a_config_write: assert property (p_config_write) else $error("pin mode write lost");

    property p_open_drain;
        alert_mode |=> !o_pin_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("alert drove the pin high");

    property p_read_clear_two;
        (rd_two && i_ool.two == 8'h00) |=> (q.status_two == 8'h00);
    endproperty
    a_read_clear_two: assert property (p_read_clear_two) else $error("read did not clear ended flag two");

    property p_status_one_rdata;
        rd_one |=> (o_rdata[6:0] == $past(q.status_one));
    endproperty
    a_status_one_rdata: assert property (p_status_one_rdata) else $error("status one read data wrong");

    property p_status_two_rdata;
        rd_two |=> (o_rdata == $past(q.status_two));
    endproperty
    a_status_two_rdata: assert property (p_status_two_rdata) else $error("status two read data wrong");

    property p_rdata_hold;
        !i_req.rd |=> $stable(o_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

    property p_unmapped_read;
        (i_req.rd && i_req.addr != LAM_ADDR_STATUS_ONE && i_req.addr != LAM_ADDR_STATUS_TWO
            && i_req.addr != LAM_ADDR_MASK_ONE && i_req.addr != LAM_ADDR_MASK_TWO
            && i_req.addr != LAM_ADDR_CONFIG_THREE) |=> (o_rdata == LAM_RDATA_UNMAPPED);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

    // ==========================================
    // Per-source masking
    // Lone masked source keeps pin released
    property p_mask_remote_two_temp;
        (alert_mode && q.status_two == 8'h00 && q.status_one == (7'h01 << LAM_BIT_REMOTE_TWO_TEMP)
            && q.mask_one[LAM_BIT_REMOTE_TWO_TEMP]) |=> !o_pin_oe;
    endproperty
    a_mask_remote_two_temp: assert property (p_mask_remote_two_temp) else $error("remote two temp mask ignored");

    property p_mask_local_temp;
        (alert_mode && q.status_two == 8'h00 && q.status_one == (7'h01 << LAM_BIT_LOCAL_TEMP)
            && q.mask_one[LAM_BIT_LOCAL_TEMP]) |=> !o_pin_oe;
    endproperty
    a_mask_local_temp: assert property (p_mask_local_temp) else $error("local temp mask ignored");

    property p_mask_remote_one_temp;
        (alert_mode && q.status_two == 8'h00 && q.status_one == (7'h01 << LAM_BIT_REMOTE_ONE_TEMP)
            && q.mask_one[LAM_BIT_REMOTE_ONE_TEMP]) |=> !o_pin_oe;
    endproperty
    a_mask_remote_one_temp: assert property (p_mask_remote_one_temp) else $error("remote one temp mask ignored");

    property p_mask_five_volt;
        (alert_mode && q.status_two == 8'h00 && q.status_one == (7'h01 << LAM_BIT_FIVE_VOLT)
            && q.mask_one[LAM_BIT_FIVE_VOLT]) |=> !o_pin_oe;
    endproperty
    a_mask_five_volt: assert property (p_mask_five_volt) else $error("5 V mask ignored");

    property p_mask_supply;
        (alert_mode && q.status_two == 8'h00 && q.status_one == (7'h01 << LAM_BIT_SUPPLY)
            && q.mask_one[LAM_BIT_SUPPLY]) |=> !o_pin_oe;
    endproperty
    a_mask_supply: assert property (p_mask_supply) else $error("supply mask ignored");

    property p_mask_core;
        (alert_mode && q.status_two == 8'h00 && q.status_one == (7'h01 << LAM_BIT_CORE)
            && q.mask_one[LAM_BIT_CORE]) |=> !o_pin_oe;
    endproperty
    a_mask_core: assert property (p_mask_core) else $error("core mask ignored");

    property p_mask_two_half_volt;
        (alert_mode && q.status_two == 8'h00 && q.status_one == (7'h01 << LAM_BIT_TWO_HALF_VOLT)
            && q.mask_one[LAM_BIT_TWO_HALF_VOLT]) |=> !o_pin_oe;
    endproperty
    a_mask_two_half_volt: assert property (p_mask_two_half_volt) else $error("2.5 V mask ignored");

    property p_mask_remote_two_diode;
        (alert_mode && q.status_one == 7'h00 && q.status_two == (8'h01 << LAM_BIT_REMOTE_TWO_DIODE)
            && q.mask_one[LAM_BIT_SUMMARY] && q.mask_two[LAM_BIT_REMOTE_TWO_DIODE]) |=> !o_pin_oe;
    endproperty
    a_mask_remote_two_diode: assert property (p_mask_remote_two_diode) else $error("diode two mask ignored");

    property p_mask_remote_one_diode;
        (alert_mode && q.status_one == 7'h00 && q.status_two == (8'h01 << LAM_BIT_REMOTE_ONE_DIODE)
            && q.mask_one[LAM_BIT_SUMMARY] && q.mask_two[LAM_BIT_REMOTE_ONE_DIODE]) |=> !o_pin_oe;
    endproperty
    a_mask_remote_one_diode: assert property (p_mask_remote_one_diode) else $error("diode one mask ignored");

    property p_mask_fan_four;
        (alert_mode && q.status_one == 7'h00 && q.status_two == (8'h01 << LAM_BIT_FAN_FOUR)
            && q.mask_one[LAM_BIT_SUMMARY] && q.mask_two[LAM_BIT_FAN_FOUR]) |=> !o_pin_oe;
    endproperty
    a_mask_fan_four: assert property (p_mask_fan_four) else $error("fan four mask ignored");

    property p_mask_fan_three;
        (alert_mode && q.status_one == 7'h00 && q.status_two == (8'h01 << LAM_BIT_FAN_THREE)
            && q.mask_one[LAM_BIT_SUMMARY] && q.mask_two[LAM_BIT_FAN_THREE]) |=> !o_pin_oe;
    endproperty
    a_mask_fan_three: assert property (p_mask_fan_three) else $error("fan three mask ignored");

    property p_mask_fan_two;
        (alert_mode && q.status_one == 7'h00 && q.status_two == (8'h01 << LAM_BIT_FAN_TWO)
            && q.mask_one[LAM_BIT_SUMMARY] && q.mask_two[LAM_BIT_FAN_TWO]) |=> !o_pin_oe;
    endproperty
    a_mask_fan_two: assert property (p_mask_fan_two) else $error("fan two mask ignored");

    property p_mask_fan_one;
        (alert_mode && q.status_one == 7'h00 && q.status_two == (8'h01 << LAM_BIT_FAN_ONE)
            && q.mask_one[LAM_BIT_SUMMARY] && q.mask_two[LAM_BIT_FAN_ONE]) |=> !o_pin_oe;
    endproperty
    a_mask_fan_one: assert property (p_mask_fan_one) else $error("fan one mask ignored");

    property p_mask_overtemp;
        (alert_mode && q.status_one == 7'h00 && q.status_two == (8'h01 << LAM_BIT_OVERTEMP)
            && q.mask_one[LAM_BIT_SUMMARY] && q.mask_two[LAM_BIT_OVERTEMP]) |=> !o_pin_oe;
    endproperty
    a_mask_overtemp: assert property (p_mask_overtemp) else $error("overtemperature mask ignored");

    property p_mask_twelve_volt;
        (alert_mode && q.status_one == 7'h00 && q.status_two == (8'h01 << LAM_BIT_TWELVE_VOLT)
            && q.mask_one[LAM_BIT_SUMMARY] && q.mask_two[LAM_BIT_TWELVE_VOLT]) |=> !o_pin_oe;
    endproperty
    a_mask_twelve_volt: assert property (p_mask_twelve_volt) else $error("12 V mask ignored");

    c_alert: cover property (q.config_three[0] ##1 $rose(o_pin_oe));
    c_read_clear: cover property ($fell(|q.status_one));
    c_masked: cover property (q.status_two != 8'h00 && !alert_active && q.mask_one[7]);
    c_masked_one: cover property (alert_mode && q.status_one != 7'h00 && !alert_active);
    c_pwm_follow: cover property (!alert_mode ##1 $changed(o_pin_o));

endmodule

// file: src/lam_pkg.sv
// Contract
// - Out-of-limit channel sets its status bit
// - Status bit sticky until cleared-condition read
// - Alert low while unmasked flag pending
// - Mask blocks alert only, status still sets
// - First mask bit 7 enables second-mask masking
// - First mask bits 6..4 mask temperature channels
// - First mask bits 3..0 mask voltage channels
// - Second mask bits 7,6 mask diode faults
// - Second mask bits 5..2 mask fans
// - Second mask bit 1 masks overtemperature
// - Second mask bit 0 masks 12 V
// - Mask registers at 0x74 and 0x75, writable
// - Status one bit 7 summarises status two
// - Status read clears only ended conditions
// - Alert shares pin with PWM two, config-selected
package lam_pkg;

    // ==========================================
    // Register map
    localparam logic [7:0] LAM_ADDR_STATUS_ONE = 8'h41;
    localparam logic [7:0] LAM_ADDR_STATUS_TWO = 8'h42;
    localparam logic [7:0] LAM_ADDR_MASK_ONE = 8'h74;
    localparam logic [7:0] LAM_ADDR_MASK_TWO = 8'h75;
    localparam logic [7:0] LAM_ADDR_CONFIG_THREE = 8'h78;

    // ==========================================
    // Reset values
    localparam logic [7:0] LAM_RST_MASK = 8'h00;
    localparam logic [7:0] LAM_RST_CONFIG = 8'h00;
    localparam logic [7:0] LAM_RST_STATUS = 8'h00;
    localparam logic [7:0] LAM_RDATA_UNMAPPED = 8'h00;

    // ==========================================
    // Field positions
    localparam int LAM_BIT_SUMMARY = 7;
    localparam int LAM_BIT_REMOTE_TWO_TEMP = 6;
    localparam int LAM_BIT_LOCAL_TEMP = 5;
    localparam int LAM_BIT_REMOTE_ONE_TEMP = 4;
    localparam int LAM_BIT_FIVE_VOLT = 3;
    localparam int LAM_BIT_SUPPLY = 2;
    localparam int LAM_BIT_CORE = 1;
    localparam int LAM_BIT_TWO_HALF_VOLT = 0;
    localparam int LAM_BIT_REMOTE_TWO_DIODE = 7;
    localparam int LAM_BIT_REMOTE_ONE_DIODE = 6;
    localparam int LAM_BIT_FAN_FOUR = 5;
    localparam int LAM_BIT_FAN_THREE = 4;
    localparam int LAM_BIT_FAN_TWO = 3;
    localparam int LAM_BIT_FAN_ONE = 2;
    localparam int LAM_BIT_OVERTEMP = 1;
    localparam int LAM_BIT_TWELVE_VOLT = 0;
    localparam int LAM_BIT_ALERT_SELECT = 0;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lam_reg_req_t;

    typedef struct packed {
        logic [6:0] one;
        logic [7:0] two;
    } lam_ool_t;

    typedef struct packed {
        logic [6:0] status_one;
        logic [7:0] status_two;
        logic [7:0] mask_one;
        logic [7:0] mask_two;
        logic [7:0] config_three;
        logic [7:0] rdata;
        logic       pin_o;
        logic       pin_oe;
    } lam_state_t;

endpackage

// file: verif/lam_pullup_host.sv
// ==========================================
// Host side of the shared pin
module lam_pullup_host
(
    input wire logic i_pin_o,
    input wire logic i_pin_oe,
    output logic o_pin_level
);
    timeunit 1ns;
    timeprecision 1ps;

    // Released pin is pulled up by the board
    assign o_pin_level = i_pin_oe ? i_pin_o : 1'b1;
endmodule

// file: verif/tb_limit_alert_mask_logic.sv
module tb_limit_alert_mask_logic;
    import lam_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'b0;
    logic i_arst_n = 1'b0;
    lam_reg_req_t req = '0;
    lam_ool_t second_status_summary = '0;
    logic pwm = 1'b0;
    logic [7:0] rdata;
    logic pin_o, pin_oe, pin;
    logic [7:0] sa, se;
    int fails = 0;
    int cmp_count = 0;

    lam_alert dut_u (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_req(req), .i_ool(second_status_summary),
        .i_pwm_channel_two(pwm), .o_rdata(rdata), .o_pin_o(pin_o), .o_pin_oe(pin_oe));
    lam_pullup_host host_u (.i_pin_o(pin_o), .i_pin_oe(pin_oe), .o_pin_level(pin));

    initial
    begin
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    // ==========================================
    // Bench tasks
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        tick(1);
        req = '0;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        tick(1);
        req = '0;
        tick(1);
        chk("rdata", rdata, e);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        fails++;
        end_of_test();
    end

    // ==========================================
    // Tests
    initial
    begin
        repeat (4) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_arst_n = 1'b1;
        rd(LAM_ADDR_MASK_ONE, LAM_RST_MASK);
        rd(LAM_ADDR_MASK_TWO, LAM_RST_MASK);
        rd(LAM_ADDR_CONFIG_THREE, LAM_RST_CONFIG);
        rd(8'h10, LAM_RDATA_UNMAPPED);
        wr(LAM_ADDR_STATUS_ONE, 8'hFF);
        rd(LAM_ADDR_STATUS_ONE, LAM_RST_STATUS);
        wr(LAM_ADDR_MASK_ONE, 8'hA5);
        rd(LAM_ADDR_MASK_ONE, 8'hA5);
        $display("test registers done");
        pwm = 1'b1;
        tick(2);
        chk("pin", {7'h00, pin}, 8'h01);
        pwm = 1'b0;
        tick(2);
        chk("pin", {7'h00, pin}, 8'h00);
        wr(LAM_ADDR_CONFIG_THREE, 8'h01);
        wr(LAM_ADDR_MASK_ONE, 8'h00);
        tick(2);
        chk("pin", {7'h00, pin}, 8'h01);
        $display("test pin mode done");
        for (int j = 0; j < 15; j++)
        begin
            second_status_summary = lam_ool_t'(15'h0001 << j);
            tick(3);
            chk("pin", {7'h00, pin}, 8'h00);
            sa = (j < 8) ? LAM_ADDR_STATUS_TWO : LAM_ADDR_STATUS_ONE;
            se = (j < 8) ? 8'(1 << j) : 8'(1 << (j - 8));
            if (j < 8)
            begin
                wr(LAM_ADDR_MASK_TWO, se);
                tick(2);
                chk("pin", {7'h00, pin}, 8'h00);
                wr(LAM_ADDR_MASK_ONE, 8'h80);
                rd(LAM_ADDR_STATUS_ONE, 8'h80);
            end
            else
                wr(LAM_ADDR_MASK_ONE, se);
            tick(2);
            chk("pin", {7'h00, pin}, 8'h01);
            rd(sa, se);
            second_status_summary = '0;
            wr(LAM_ADDR_MASK_ONE, 8'h00);
            wr(LAM_ADDR_MASK_TWO, 8'h00);
            tick(2);
            chk("pin", {7'h00, pin}, 8'h00);
            rd(sa, se);
            tick(2);
            chk("pin", {7'h00, pin}, 8'h01);
            rd(sa, 8'h00);
        end
        $display("test sources done");
        end_of_test();
    end
endmodule
